// ### src/dtio_top.sv
`include "dtio_params.svh"
`default_nettype none
// Overview of operation
// - Three curve digits select analog curves, default 321.
// - Curves one-three two points, four-five four.
// - Digit zero: below minimum uses minimum-point setting.
// - Digit one: below minimum reports zero percent.
// - Switch inputs one-three delay 0-3600.0 s.
// - Other switch inputs act without delay.
// - Two five-digit polarity settings, default zero.
// - Polarity zero: connected to common means active.
// - Polarity one: connected to common means inactive.
// - Pulse reference comes only from switch five.
// - Second analog type: zero voltage, one current.
// - Fast output mode: zero pulse, one switch.
// - Pulse train never exceeds 50 kHz.
// - Five output function selects, defaults 0,2,0,1,4.
// - Code 0 off, 1 running, 2 fault stop.
// - Input above maximum clamps to maximum.
module dtio_top #(
    parameter int TICK_CYCLES = `DTIO_CLK_HZ / 1000 * `DTIO_TICK_MS
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire dtio_pkg::dtio_cfg_wr_t CFG_WR,
    output logic CFG_REJECT,
    input wire logic [9:0] SW_CONNECTED,
    output logic [9:0] SW_ACTIVE,
    output logic PULSE_IN,
    input wire logic [2:0][11:0] AIN_LEVEL,
    input wire logic [4:0][11:0] CURVE_MIN,
    input wire logic [4:0][11:0] CURVE_MAX,
    output dtio_pkg::dtio_ain_res_t [2:0] AIN_RESULT,
    output logic IN_TWO_CURRENT,
    input wire logic DRIVE_RUNNING,
    input wire logic DRIVE_FAULT_STOP,
    input wire logic [31:0] FUNC_EXTRA,
    input wire logic [15:0] FAST_HALF_PERIOD,
    output logic FAST_MUX_OUTPUT,
    output logic FAST_OUTPUT_SWITCH_MODE,
    output logic BOARD_RELAY_OUT,
    output logic EXT_RELAY_OUT,
    output logic OPEN_COLLECTOR_OUT_ONE,
    output logic EXTENSION_DIGITAL_OUT
);
    import dtio_pkg::*;

    localparam logic [15:0] TRAIN_MIN_HALF = 16'(`DTIO_TRAIN_MIN_HALF);

    dtio_state_t q;
    dtio_state_t d;
    logic [9:0] sw_cond;
    logic [2:0] sw_delayed;
    logic [2:0][11:0] ain_lo;
    logic [2:0][11:0] ain_hi;
    logic curve_ok;
    logic [15:0] train_half;

    // ********************************************
    // Helpers
    // ********************************************
    function automatic logic bin_digits_ok(input logic [19:0] v, input int n);
        logic ok;
        ok = 1'b1;
        for (int k = 0; k < 5; k++) begin
            if (k < n) begin
                ok = ok && (v[4 * k +: 4] <= 4'h1);
            end else begin
                ok = ok && (v[4 * k +: 4] == 4'h0);
            end
        end
        return ok;
    endfunction

    function automatic logic fn_value(input logic [4:0] code, input logic run, input logic fault,
                                      input logic [31:0] extra);
        case (code)
            `DTIO_FN_NONE: fn_value = 1'b0;
            `DTIO_FN_RUN: fn_value = run;
            `DTIO_FN_FAULT: fn_value = fault;
            default: fn_value = extra[code];
        endcase
    endfunction

    // Curve digits are decimal; each must name one of the five curves.
    assign curve_ok = CFG_WR.data[19:12] == 8'h00 &&
                      CFG_WR.data[11:8] >= 4'(`DTIO_CURVE_FIRST) && CFG_WR.data[11:8] <= 4'(`DTIO_CURVE_LAST) &&
                      CFG_WR.data[7:4] >= 4'(`DTIO_CURVE_FIRST) && CFG_WR.data[7:4] <= 4'(`DTIO_CURVE_LAST) &&
                      CFG_WR.data[3:0] >= 4'(`DTIO_CURVE_FIRST) && CFG_WR.data[3:0] <= 4'(`DTIO_CURVE_LAST);

    // A requested half period below the limit is raised to it, so no setting can overrun the pin.
    assign train_half = (FAST_HALF_PERIOD < TRAIN_MIN_HALF) ? TRAIN_MIN_HALF : FAST_HALF_PERIOD;

    // ********************************************
    // Switch input conditioning
    // ********************************************
    assign sw_cond = SW_CONNECTED ^ q.cfg.pol;

    // Only the first three inputs carry a timer; the rest stay lean on purpose.
    for (genvar i = 0; i < `DTIO_DELAYED_SW; i++) begin : g_delay
        dtio_delay #(
            .TICK_CYCLES(TICK_CYCLES)
        ) u_delay (
            .clk_sys(CLK_SYS),
            .reset_n(RESET_N),
            .in_level(sw_cond[i]),
            .delay_tenths(q.cfg.delay[i]),
            .out_level(sw_delayed[i])
        );
    end

    for (genvar i = 0; i < 3; i++) begin : g_ain
        assign ain_lo[i] = CURVE_MIN[3'(q.cfg.curve[i] - 3'h1)];
        assign ain_hi[i] = CURVE_MAX[3'(q.cfg.curve[i] - 3'h1)];
    end

    // ********************************************
    // Next state
    // ********************************************
    always_comb begin
        d = q;
        d.reject = 1'b0;
        if (CFG_WR.we) begin
            case (CFG_WR.sel)
                DTIO_SEL_CURVE: begin
                    if (curve_ok) begin
                        d.cfg.curve = {CFG_WR.data[10:8], CFG_WR.data[6:4], CFG_WR.data[2:0]};
                    end else begin
                        d.reject = 1'b1;
                    end
                end
                DTIO_SEL_BELOW: begin
                    d.reject = !bin_digits_ok(CFG_WR.data, 3);
                    if (!d.reject) d.cfg.below = {CFG_WR.data[8], CFG_WR.data[4], CFG_WR.data[0]};
                end
                DTIO_SEL_DELAY_ONE, DTIO_SEL_DELAY_TWO, DTIO_SEL_DELAY_THREE: begin
                    d.reject = CFG_WR.data > `DTIO_DELAY_MAX_TENTHS;
                    if (!d.reject) d.cfg.delay[2'(CFG_WR.sel - DTIO_SEL_DELAY_ONE)] = CFG_WR.data[15:0];
                end
                DTIO_SEL_POL_LOW, DTIO_SEL_POL_HIGH: begin
                    d.reject = !bin_digits_ok(CFG_WR.data, 5);
                    if (!d.reject && CFG_WR.sel == DTIO_SEL_POL_LOW) begin
                        d.cfg.pol[4:0] = {CFG_WR.data[16], CFG_WR.data[12], CFG_WR.data[8], CFG_WR.data[4],
                                          CFG_WR.data[0]};
                    end else if (!d.reject) begin
                        d.cfg.pol[9:5] = {CFG_WR.data[16], CFG_WR.data[12], CFG_WR.data[8], CFG_WR.data[4],
                                          CFG_WR.data[0]};
                    end
                end
                DTIO_SEL_IN_TWO_TYPE: begin
                    d.reject = !bin_digits_ok(CFG_WR.data, 1);
                    if (!d.reject) d.cfg.in_two_current = CFG_WR.data[0];
                end
                DTIO_SEL_FAST_MODE: begin
                    d.reject = !bin_digits_ok(CFG_WR.data, 1);
                    if (!d.reject) d.cfg.fast_switch = CFG_WR.data[0];
                end
                DTIO_SEL_FUNC_FAST, DTIO_SEL_FUNC_BOARD, DTIO_SEL_FUNC_EXT_RELAY, DTIO_SEL_FUNC_OC_ONE,
                DTIO_SEL_FUNC_EXT_OUT: begin
                    d.reject = CFG_WR.data[19:5] != 15'h0000;
                    if (!d.reject) d.cfg.func[3'(CFG_WR.sel - DTIO_SEL_FUNC_FAST)] = CFG_WR.data[4:0];
                end
                default: d.reject = 1'b1;
            endcase
        end
        d.sw = sw_cond[9:3];
        d.pulse_in = (`DTIO_PULSE_SW < `DTIO_DELAYED_SW) ? sw_delayed[0] : sw_cond[`DTIO_PULSE_SW];
        for (int i = 0; i < 3; i++) begin
            d.ain[i][13] = AIN_LEVEL[i] < ain_lo[i];
            d.ain[i][12] = d.ain[i][13] && q.cfg.below[i];
            if (d.ain[i][13]) begin
                d.ain[i][11:0] = ain_lo[i];
            end else if (AIN_LEVEL[i] > ain_hi[i]) begin
                d.ain[i][11:0] = ain_hi[i];
            end else begin
                d.ain[i][11:0] = AIN_LEVEL[i];
            end
            d.ain[i][14] = q.cfg.curve[i] >= `DTIO_CURVE_FOUR_POINT;
            d.ain[i][17:15] = q.cfg.curve[i];
        end
        // A stopped train holds its level so that a restart never shortens a half period.
        if (q.cfg.fast_switch) begin
            d.train_cnt = '0;
            d.train_level = fn_value(q.cfg.func[0], DRIVE_RUNNING, DRIVE_FAULT_STOP, FUNC_EXTRA);
        end else if (FAST_HALF_PERIOD == 16'h0000) begin
            d.train_cnt = '0;
        end else if (q.train_cnt >= train_half - 16'h0001) begin
            d.train_cnt = '0;
            d.train_level = !q.train_level;
        end else begin
            d.train_cnt = q.train_cnt + 16'h0001;
        end
        for (int k = 0; k < 4; k++) begin
            d.outs[k] = fn_value(q.cfg.func[k + 1], DRIVE_RUNNING, DRIVE_FAULT_STOP, FUNC_EXTRA);
        end
        d.in_two_current = q.cfg.in_two_current;
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            q <= '0;
            q.cfg.curve <= `DTIO_CURVE_RST;
            q.cfg.below <= `DTIO_BELOW_RST;
            q.cfg.delay <= {3{`DTIO_DELAY_RST}};
            q.cfg.pol <= `DTIO_POL_RST;
            q.cfg.in_two_current <= `DTIO_TYPE_RST;
            q.cfg.fast_switch <= `DTIO_FMODE_RST;
            q.cfg.func <= `DTIO_FUNC_RST;
        end else begin
            q <= d;
        end
    end

    assign CFG_REJECT = q.reject;
    assign SW_ACTIVE = {q.sw, sw_delayed};
    assign PULSE_IN = q.pulse_in;
    assign AIN_RESULT = q.ain;
    assign IN_TWO_CURRENT = q.in_two_current;
    assign FAST_MUX_OUTPUT = q.train_level;
    assign FAST_OUTPUT_SWITCH_MODE = q.cfg.fast_switch;
    assign {EXTENSION_DIGITAL_OUT, OPEN_COLLECTOR_OUT_ONE, EXT_RELAY_OUT, BOARD_RELAY_OUT} = q.outs;

    // ********************************************
    // Assertions
    // ********************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    logic [15:0] gap_q;
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) gap_q <= '0;
        else if (d.train_level != q.train_level) gap_q <= '0;
        else if (gap_q != 16'hffff) gap_q <= gap_q + 16'h0001;
    end

    property p_curve_reject;
        (CFG_WR.we && CFG_WR.sel == DTIO_SEL_CURVE && !curve_ok) |=> $stable(q.cfg.curve) && CFG_REJECT;
    endproperty
    a_curve_reject: assert property (p_curve_reject) else $error("Bad curve digit was accepted.");

    property p_polarity;
        1'b1 |=> SW_ACTIVE[9:3] == $past(SW_CONNECTED[9:3] ^ q.cfg.pol[9:3]);
    endproperty
    a_polarity: assert property (p_polarity) else $error("Undelayed input sense is wrong.");

    property p_pulse_src;
        1'b1 |=> PULSE_IN == $past(SW_CONNECTED[`DTIO_PULSE_SW] ^ q.cfg.pol[`DTIO_PULSE_SW]);
    endproperty
    a_pulse_src: assert property (p_pulse_src) else $error("Pulse input not taken from input five.");

    property p_below_zero;
        (AIN_LEVEL[1] < ain_lo[1]) |=> AIN_RESULT[1].below && AIN_RESULT[1].zero == $past(q.cfg.below[1]);
    endproperty
    a_below_zero: assert property (p_below_zero) else $error("Below-minimum handling is wrong.");

    property p_min_point;
        (AIN_LEVEL[0] < ain_lo[0] && !q.cfg.below[0]) |=>
            AIN_RESULT[0].value == $past(ain_lo[0]) && !AIN_RESULT[0].zero;
    endproperty
    a_min_point: assert property (p_min_point) else $error("Minimum point not used.");

    property p_clamp;
        (AIN_LEVEL[1] > ain_hi[1] && ain_lo[1] <= ain_hi[1]) |=> AIN_RESULT[1].value == $past(ain_hi[1]);
    endproperty
    a_clamp: assert property (p_clamp) else $error("Input above maximum not clamped.");

    property p_type_write;
        (CFG_WR.we && CFG_WR.sel == DTIO_SEL_IN_TWO_TYPE && CFG_WR.data == 20'h00001) |=> ##1 IN_TWO_CURRENT;
    endproperty
    a_type_write: assert property (p_type_write) else $error("Current mode not selected.");

    property p_relay_fn;
        (q.cfg.func[1] == `DTIO_FN_RUN && $stable(q.cfg.func[1])) |=> BOARD_RELAY_OUT == $past(DRIVE_RUNNING);
    endproperty
    a_relay_fn: assert property (p_relay_fn) else $error("Running function not followed.");

    property p_fast_rate;
        (!q.cfg.fast_switch && d.train_level != q.train_level) |-> gap_q >= TRAIN_MIN_HALF - 16'h0001;
    endproperty
    a_fast_rate: assert property (p_fast_rate) else $error("Pulse train faster than its limit.");

    property p_switch_mode;
        (q.cfg.fast_switch && q.cfg.func[0] == `DTIO_FN_NONE) |=> !FAST_MUX_OUTPUT;
    endproperty
    a_switch_mode: assert property (p_switch_mode) else $error("Idle switch output driven.");

    c_delayed_rise: cover property ($rose(SW_ACTIVE[0]) && q.cfg.delay[0] != 16'h0000);
    c_reject: cover property (CFG_REJECT && $past(CFG_WR.sel) == DTIO_SEL_CURVE);
    c_zero: cover property (AIN_RESULT[0].zero);
    c_fast_toggle: cover property (!q.cfg.fast_switch && $changed(FAST_MUX_OUTPUT));

endmodule
`default_nettype wire

// ### src/dtio_params.svh
`ifndef DTIO_PARAMS_SVH
`define DTIO_PARAMS_SVH

// ********************************************
// Timing
// ********************************************
`define DTIO_CLK_HZ 25000000
`define DTIO_TICK_MS 100
`define DTIO_DELAY_MAX_TENTHS 20'h08ca0
`define DTIO_TRAIN_MAX_HZ 50000
`define DTIO_TRAIN_MIN_HALF ((`DTIO_CLK_HZ + 2 * `DTIO_TRAIN_MAX_HZ - 1) / (2 * `DTIO_TRAIN_MAX_HZ))

// ********************************************
// Field positions and counts
// ********************************************
`define DTIO_PULSE_SW 4
`define DTIO_DELAYED_SW 3
`define DTIO_CURVE_FIRST 3'h1
`define DTIO_CURVE_LAST 3'h5
`define DTIO_CURVE_FOUR_POINT 3'h4

// ********************************************
// Reset values and function codes
// ********************************************
`define DTIO_CURVE_RST 9'h0d1
`define DTIO_BELOW_RST 3'h0
`define DTIO_POL_RST 10'h000
`define DTIO_DELAY_RST 16'h0000
`define DTIO_TYPE_RST 1'h0
`define DTIO_FMODE_RST 1'h0
`define DTIO_FUNC_RST 25'h0408040
`define DTIO_FN_NONE 5'h00
`define DTIO_FN_RUN 5'h01
`define DTIO_FN_FAULT 5'h02

`endif

// ### src/dtio_pkg.sv
`default_nettype none
package dtio_pkg;

    typedef enum logic [3:0] {
        DTIO_SEL_CURVE = 4'h0,
        DTIO_SEL_BELOW = 4'h1,
        DTIO_SEL_DELAY_ONE = 4'h2,
        DTIO_SEL_DELAY_TWO = 4'h3,
        DTIO_SEL_DELAY_THREE = 4'h4,
        DTIO_SEL_POL_LOW = 4'h5,
        DTIO_SEL_POL_HIGH = 4'h6,
        DTIO_SEL_IN_TWO_TYPE = 4'h7,
        DTIO_SEL_FAST_MODE = 4'h8,
        DTIO_SEL_FUNC_FAST = 4'h9,
        DTIO_SEL_FUNC_BOARD = 4'ha,
        DTIO_SEL_FUNC_EXT_RELAY = 4'hb,
        DTIO_SEL_FUNC_OC_ONE = 4'hc,
        DTIO_SEL_FUNC_EXT_OUT = 4'hd
    } dtio_sel_t;

    typedef struct packed {
        logic we;
        dtio_sel_t sel;
        logic [19:0] data;
    } dtio_cfg_wr_t;

    typedef struct packed {
        logic [2:0][2:0] curve;
        logic [2:0] below;
        logic [2:0][15:0] delay;
        logic [9:0] pol;
        logic in_two_current;
        logic fast_switch;
        logic [4:0][4:0] func;
    } dtio_cfg_t;

    typedef struct packed {
        logic [2:0] curve;
        logic four_point;
        logic below;
        logic zero;
        logic [11:0] value;
    } dtio_ain_res_t;

    typedef struct packed {
        logic [31:0] pre;
        logic [15:0] tenths;
        logic out;
    } dtio_dly_t;

    typedef struct packed {
        dtio_cfg_t cfg;
        logic reject;
        logic [9:3] sw;
        logic pulse_in;
        logic [2:0][17:0] ain;
        logic [15:0] train_cnt;
        logic train_level;
        logic [3:0] outs;
        logic in_two_current;
    } dtio_state_t;

endpackage
`default_nettype wire

// ### src/dtio_delay.sv
`include "dtio_params.svh"
`default_nettype none
module dtio_delay #(
    parameter int TICK_CYCLES = `DTIO_CLK_HZ / 1000 * `DTIO_TICK_MS
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic in_level,
    input wire logic [15:0] delay_tenths,
    output logic out_level
);
    import dtio_pkg::*;

    dtio_dly_t q;
    dtio_dly_t d;

    // A change must persist for the whole delay; a shorter glitch restarts it.
    always_comb begin
        d = q;
        if (in_level == q.out) begin
            d.pre = '0;
            d.tenths = '0;
        end else if (q.tenths >= delay_tenths) begin
            d.out = in_level;
            d.pre = '0;
            d.tenths = '0;
        end else if (q.pre == 32'(TICK_CYCLES - 1)) begin
            d.pre = '0;
            d.tenths = q.tenths + 16'h0001;
        end else begin
            d.pre = q.pre + 32'h00000001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign out_level = q.out;

    // ********************************************
    // Assertions
    // ********************************************
    property p_settle;
        @(posedge clk_sys) disable iff (!reset_n)
        (in_level != q.out && q.tenths >= delay_tenths) |=> out_level == $past(in_level);
    endproperty
    a_settle: assert property (p_settle) else $error("Delayed input did not settle.");

    property p_wait;
        @(posedge clk_sys) disable iff (!reset_n)
        (in_level != q.out && q.tenths < delay_tenths) |=> $stable(out_level);
    endproperty
    a_wait: assert property (p_wait) else $error("Delayed input changed early.");

    property p_hold;
        @(posedge clk_sys) disable iff (!reset_n)
        (in_level == q.out) |=> $stable(out_level) && q.tenths == 16'h0000;
    endproperty
    a_hold: assert property (p_hold) else $error("Delay timer ran without a change.");

endmodule
`default_nettype wire

// ### verif/dtio_field.sv
`default_nettype none
// ****************
// Field side
// ****************
module dtio_field #(
    parameter logic [11:0] MIN_BASE = 12'h100,
    parameter logic [11:0] MAX_BASE = 12'he00
) (
    input wire logic [9:0] closed_req,
    input wire logic [2:0][11:0] level_req,
    input wire logic in_two_current,
    output logic [9:0] sw_connected,
    output logic [2:0][11:0] ain_level,
    output logic [4:0][11:0] curve_min,
    output logic [4:0][11:0] curve_max,
    output logic jumper_current
);
    // Contacts are ideal here, so any bounce seen by the block is made on purpose by the bench.
    always_comb begin
        sw_connected = closed_req;
        ain_level = level_req;
        jumper_current = in_two_current;
        for (int k = 0; k < 5; k++) begin
            curve_min[k] = MIN_BASE + 12'(k * 16);
            curve_max[k] = MAX_BASE + 12'(k * 16);
        end
    end
endmodule
`default_nettype wire

// ### verif/dtio_top_test.sv
`default_nettype none
module dtio_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    import dtio_pkg::*;
    localparam logic [11:0] MIN_BASE = 12'h100;
    localparam logic [11:0] MAX_BASE = 12'he00;
    logic clk_sys, reset_n, cfg_reject, pulse_in, in_two_current, jumper_current, drive_running, drive_fault_stop;
    logic fast_mux_output, fast_switch_mode, board_out, ext_relay_out, oc_one_out, ext_out;
    dtio_cfg_wr_t cfg_wr;
    logic [9:0] closed_req, sw_connected, sw_active;
    logic [2:0][11:0] level_req, ain_level;
    logic [4:0][11:0] curve_min, curve_max;
    dtio_ain_res_t [2:0] ain_result;
    logic [31:0] func_extra;
    logic [15:0] fast_half_period;
    int num_errors = 0;
    int n_checks = 0;
    int n;

    dtio_top #(.TICK_CYCLES(4)) u_dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .CFG_WR(cfg_wr),
        .CFG_REJECT(cfg_reject), .SW_CONNECTED(sw_connected), .SW_ACTIVE(sw_active), .PULSE_IN(pulse_in),
        .AIN_LEVEL(ain_level), .CURVE_MIN(curve_min), .CURVE_MAX(curve_max), .AIN_RESULT(ain_result),
        .IN_TWO_CURRENT(in_two_current), .DRIVE_RUNNING(drive_running), .DRIVE_FAULT_STOP(drive_fault_stop),
        .FUNC_EXTRA(func_extra), .FAST_HALF_PERIOD(fast_half_period), .FAST_MUX_OUTPUT(fast_mux_output),
        .FAST_OUTPUT_SWITCH_MODE(fast_switch_mode), .BOARD_RELAY_OUT(board_out), .EXT_RELAY_OUT(ext_relay_out),
        .OPEN_COLLECTOR_OUT_ONE(oc_one_out), .EXTENSION_DIGITAL_OUT(ext_out));

    dtio_field #(.MIN_BASE(MIN_BASE), .MAX_BASE(MAX_BASE)) u_field (.closed_req(closed_req),
        .level_req(level_req), .in_two_current(in_two_current), .sw_connected(sw_connected),
        .ain_level(ain_level), .curve_min(curve_min), .curve_max(curve_max), .jumper_current(jumper_current));

    // ****************
    // Shared tasks
    // ****************
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    // Leaves the setting visible on every output but the timer-delayed switch inputs, the two-cycle type flag included.
    task automatic wr(input dtio_sel_t sel, input logic [19:0] data, input logic rej);
        cfg_wr.we = 1'b1;
        cfg_wr.sel = sel;
        cfg_wr.data = data;
        tick(1);
        cmp("reject", 32'(rej), 32'(cfg_reject));
        cfg_wr.we = 1'b0;
        tick(2);
    endtask

    task automatic until_change(input bit pick_fast, input int lim, output int k);
        logic v0;
        v0 = pick_fast ? fast_mux_output : sw_active[0];
        for (k = 1; k <= lim; k++) begin
            tick(1);
            if ((pick_fast ? fast_mux_output : sw_active[0]) !== v0) begin
                return;
            end
        end
        num_errors++;
        $display("MISMATCH wait expected change seen none");
        close_out();
    endtask

    function automatic logic [4:0] outs();
        return {ext_out, oc_one_out, ext_relay_out, board_out, fast_mux_output};
    endfunction

    // ****************
    // Scenarios
    // ****************
    task automatic t_defaults();
        drive_fault_stop = 1'b1;
        drive_running = 1'b1;
        func_extra = 32'h10;
        closed_req = 10'h3ff;
        tick(2);
        for (int i = 0; i < 3; i++) begin
            cmp("curve", 32'(i + 1), 32'(ain_result[i].curve));
        end
        cmp("outs", 32'h1a, 32'({outs()} & 5'h1e));
        cmp("active", 32'h3ff, 32'(sw_active));
        cmp("type", 32'h0, 32'({in_two_current, fast_switch_mode}));
        drive_fault_stop = 1'b0;
        drive_running = 1'b0;
        func_extra = 32'h0;
        closed_req = 10'h000;
        tick(2);
        cmp("outs", 32'h0, 32'(outs() & 5'h1e));
    endtask

    task automatic t_curves();
        for (int c = 1; c <= 5; c++) begin
            wr(DTIO_SEL_CURVE, {8'h00, 4'(c), 4'(c), 4'(c)}, 1'b0);
            for (int i = 0; i < 3; i++) begin
                cmp("curve", 32'(c), 32'(ain_result[i].curve));
                cmp("four", 32'(c >= 4), 32'(ain_result[i].four_point));
            end
        end
        wr(DTIO_SEL_CURVE, 20'h00999, 1'b1);
        wr(DTIO_SEL_CURVE, 20'h00106, 1'b1);
        wr(DTIO_SEL_CURVE, 20'h00150, 1'b1);
        cmp("curve", 32'h5, 32'(ain_result[1].curve));
        wr(DTIO_SEL_CURVE, 20'h00321, 1'b0);
    endtask

    task automatic t_analog();
        level_req = {MIN_BASE + 12'h025, 12'hfff, 12'h000};
        tick(2);
        cmp("below", 32'h2, 32'({ain_result[0].below, ain_result[0].zero}));
        cmp("value", 32'(MIN_BASE), 32'(ain_result[0].value));
        cmp("clamp", 32'(MAX_BASE + 12'h010), 32'(ain_result[1].value));
        cmp("inside", 32'(MIN_BASE + 12'h025), 32'(ain_result[2].value));
        wr(DTIO_SEL_BELOW, 20'h00001, 1'b0);
        cmp("zero", 32'h3, 32'({ain_result[0].below, ain_result[0].zero}));
        cmp("zero", 32'h0, 32'(ain_result[1].zero));
        level_req = '0;
        wr(DTIO_SEL_BELOW, 20'h00110, 1'b0);
        cmp("zero", 32'h6, 32'({ain_result[2].zero, ain_result[1].zero, ain_result[0].zero}));
        wr(DTIO_SEL_BELOW, 20'h00002, 1'b1);
        wr(DTIO_SEL_BELOW, 20'h00000, 1'b0);
    endtask

    task automatic t_switches();
        wr(DTIO_SEL_POL_LOW, 20'h11000, 1'b0);
        wr(DTIO_SEL_POL_HIGH, 20'h10001, 1'b0);
        cmp("active", 32'h238, 32'(sw_active));
        cmp("pulse", 32'h1, 32'(pulse_in));
        closed_req = 10'h3ff;
        tick(1);
        cmp("fast", 32'h38, 32'(sw_active[9:3]));
        tick(1);
        cmp("active", 32'h1c7, 32'(sw_active));
        cmp("pulse", 32'h0, 32'(pulse_in));
        closed_req = 10'h010;
        tick(3);
        cmp("pulse", 32'h0, 32'(pulse_in));
        wr(DTIO_SEL_POL_LOW, 20'h00002, 1'b1);
        wr(DTIO_SEL_POL_LOW, 20'h00000, 1'b0);
        wr(DTIO_SEL_POL_HIGH, 20'h00000, 1'b0);
        closed_req = 10'h000;
        tick(2);
    endtask

    task automatic t_delay();
        wr(DTIO_SEL_DELAY_ONE, 20'd2, 1'b0);
        closed_req = 10'h003;
        tick(1);
        cmp("nodelay", 32'h2, 32'(sw_active[1:0]));
        tick(4);
        closed_req = 10'h002;
        tick(3);
        closed_req = 10'h003;
        until_change(1'b0, 40, n);
        cmp("hold", 32'h1, 32'(n >= 9 && n <= 11));
        wr(DTIO_SEL_POL_LOW, 20'h00001, 1'b0);
        cmp("early", 32'h1, 32'(sw_active[0]));
        until_change(1'b0, 40, n);
        cmp("hold", 32'h1, 32'(n >= 6 && n <= 9));
        wr(DTIO_SEL_DELAY_ONE, 20'd36001, 1'b1);
        wr(DTIO_SEL_DELAY_THREE, 20'd36000, 1'b0);
        wr(DTIO_SEL_DELAY_THREE, 20'd0, 1'b0);
        wr(DTIO_SEL_POL_LOW, 20'h00000, 1'b0);
    endtask

    task automatic t_type();
        wr(DTIO_SEL_IN_TWO_TYPE, 20'h00001, 1'b0);
        cmp("current", 32'h1, 32'(in_two_current));
        wr(DTIO_SEL_IN_TWO_TYPE, 20'h00002, 1'b1);
        cmp("current", 32'h1, 32'(in_two_current));
        wr(DTIO_SEL_IN_TWO_TYPE, 20'h00000, 1'b0);
        cmp("current", 32'h0, 32'(in_two_current));
    endtask

    task automatic t_fast();
        fast_half_period = 16'd10;
        until_change(1'b1, 600, n);
        until_change(1'b1, 600, n);
        cmp("half", 32'd250, 32'(n));
        fast_half_period = 16'd300;
        until_change(1'b1, 700, n);
        until_change(1'b1, 700, n);
        cmp("half", 32'd300, 32'(n));
        wr(DTIO_SEL_FAST_MODE, 20'h00001, 1'b0);
        cmp("mode", 32'h1, 32'(fast_switch_mode));
        wr(DTIO_SEL_FUNC_FAST, 20'd32, 1'b1);
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 5; k++) begin
                wr(dtio_sel_t'(4'h9 + 4'(k)), 20'(c), 1'b0);
            end
            drive_running = 1'b1;
            drive_fault_stop = 1'b1;
            func_extra = 32'hffffffff;
            tick(2);
            cmp("on", (c == 0) ? 32'h0 : 32'h1f, 32'(outs()));
            drive_running = (c != 1);
            drive_fault_stop = (c != 2);
            func_extra = 32'hfffffff7;
            tick(2);
            cmp("off", 32'h0, 32'(outs()));
        end
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial begin
        reset_n = 1'b0;
        cfg_wr = '0;
        closed_req = '0;
        level_req = '0;
        drive_running = 1'b0;
        drive_fault_stop = 1'b0;
        func_extra = '0;
        fast_half_period = '0;
        tick(10);
        cmp("reset", 32'h0, 32'({sw_active, cfg_reject, in_two_current}));
        reset_n = 1'b1;
        t_defaults();
        t_curves();
        t_analog();
        t_switches();
        t_delay();
        t_type();
        t_fast();
        close_out();
    end
endmodule
`default_nettype wire
